/* design/rsp_consts.svh */
// constants shared by both ends of the serial output link
`ifndef RSP_CONSTS_SVH
`define RSP_CONSTS_SVH
// ---------------------------------------------------------------
// serial output control register
// ---------------------------------------------------------------
`define SOC_OFFSET 8'ha9
`define SOC_RESET 10'h000
`define SOC_ROUTE_BIT 9
`define SOC_FS_HI 8
`define SOC_FS_LO 7
`define SOC_WL_HI 6
`define SOC_WL_LO 5
`define SOC_MASTER_BIT 4
`define SOC_DIV_HI 3
`define SOC_DIV_LO 0
// ---------------------------------------------------------------
// word lengths and control frame
// ---------------------------------------------------------------
`define WL_12 6'd12
`define WL_16 6'd16
`define WL_24 6'd24
`define CTL_ADDR_BITS 8
`define CTL_DATA_BITS 10
`define CTL_FRAME_BITS 5'd19
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define HCLK_MHZ 250
`define SCLK_MAX_MHZ 80
`define SCLK_MIN_HALF ((`HCLK_MHZ + 2 * `SCLK_MAX_MHZ - 1) / (2 * `SCLK_MAX_MHZ))
// ---------------------------------------------------------------
// controller registers
// ---------------------------------------------------------------
`define HOST_CTRL 8'h00
`define HOST_SYNC 8'h04
`define HOST_CMD 8'h08
`define HOST_STATUS 8'h0c
`define HOST_RX_I 8'h10
`define HOST_RX_Q 8'h14
`define HOST_CTRL_RESET 7'h00
`endif

/* design/rsp_pkg.sv */
// state type of the device end and word length decode shared by both ends of the link
`include "rsp_consts.svh"
package rsp_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SYNC = 2'b01,
      ST_SHIFT = 2'b10
   } tx_state_t;

   function automatic logic [5:0] word_len(input logic [1:0] code);
      return code[1] ? `WL_24 : (code[0] ? `WL_16 : `WL_12);
   endfunction
endpackage

/* design/serial_link_if.sv */
// serial output link between the receiver channel and its partner
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
   logic dev_sclk_o;
   logic dev_sclk_oe;
   logic host_sclk_o;
   logic host_sclk_oe;
   logic sclk;
   logic dev_fs_o;
   logic dev_fs_oe;
   logic host_fs_o;
   logic host_fs_oe;
   logic frame_sync;
   logic sdo_o;
   logic sdo_oe;
   logic serial_data_output_line;
   logic frame_end;
   logic serial_control_input;
   // wires resolve from the enables; an undriven line reads low
   assign sclk = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe & host_sclk_o);
   assign frame_sync = dev_fs_oe ? dev_fs_o : (host_fs_oe & host_fs_o);
   assign serial_data_output_line = sdo_oe & sdo_o;
   modport device (
      output dev_sclk_o, dev_sclk_oe, dev_fs_o, dev_fs_oe,
      output sdo_o, sdo_oe, frame_end,
      input sclk, frame_sync, serial_control_input
   );
   modport host (
      output host_sclk_o, host_sclk_oe, host_fs_o, host_fs_oe,
      output serial_control_input,
      input sclk, frame_sync, serial_data_output_line, frame_end
   );
endinterface
`default_nettype wire

/* design/serial_port_device.sv */
// receiver channel serial output port with serial control input
//
// Local design decision: the AHB-Lite slave port.
`include "rsp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module serial_port_device #(
   parameter int PORT_INDEX = 0
) (
   input wire logic hclk,
   input wire logic hresetn,
   serial_link_if.device link,
   input wire logic boot_master_select_pin,
   input wire logic sample_valid,
   input wire logic [23:0] sample_i,
   input wire logic [23:0] sample_q,
   output logic [15:0] sig_i,
   output logic [15:0] sig_q,
   output logic [9:0] serial_output_control,
   output logic port_master_select
);
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   if (PORT_INDEX < 0 || PORT_INDEX > 3) begin : g_bad_port
      $error("port index must be 0 to 3");
   end

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic sclk_prev;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sclk_prev <= 1'b0;
      end else begin
         sync1 <= {boot_master_select_pin, link.sclk, link.frame_sync,
                   link.serial_control_input};
         sync2 <= sync1;
         sclk_prev <= sync2[2];
      end
   end

   // ------------------------------------------------------------
   // mode select
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_master_select <= 1'b0;
      end else if (PORT_INDEX == 0) begin
         port_master_select <= sync2[3];
      end else begin
         port_master_select <= serial_output_control[`SOC_MASTER_BIT];
      end
   end

   // ------------------------------------------------------------
   // bit clock divider for master mode
   // ------------------------------------------------------------
   // half period never shorter than the rate limit allows
   localparam logic [4:0] MIN_HALF = 5'(`SCLK_MIN_HALF);
   logic [4:0] div_cnt;
   logic gen_clk;
   logic tick;
   logic rise_ev;
   logic fall_ev;
   assign tick = port_master_select && div_cnt == 5'd0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= 5'd0;
         gen_clk <= 1'b0;
      end else if (!port_master_select) begin
         div_cnt <= 5'd0;
         gen_clk <= 1'b0;
      end else if (tick) begin
         div_cnt <= MIN_HALF - 5'd1 +
            {1'b0, serial_output_control[`SOC_DIV_HI:`SOC_DIV_LO]};
         gen_clk <= ~gen_clk;
      end else begin
         div_cnt <= div_cnt - 5'd1;
      end
   end
   assign link.dev_sclk_o = gen_clk;
   assign link.dev_sclk_oe = port_master_select;
   // in slave mode the far clock arrives late by the synchroniser only
   assign rise_ev = port_master_select ? (tick && !gen_clk)
                                       : (sync2[2] && !sclk_prev);
   assign fall_ev = port_master_select ? (tick && gen_clk)
                                       : (!sync2[2] && sclk_prev);

   // ------------------------------------------------------------
   // serial control input
   // ------------------------------------------------------------
   logic [4:0] rx_cnt;
   logic [17:0] rx_sh;
   logic [17:0] rx_word;
   assign rx_word = {rx_sh[16:0], sync2[0]};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_cnt <= 5'd0;
         rx_sh <= 18'h00000;
      end else if (fall_ev) begin
         if (rx_cnt == 5'd0) begin
            if (sync2[0]) begin
               rx_cnt <= `CTL_FRAME_BITS - 5'd1;
            end
         end else begin
            rx_sh <= rx_word;
            rx_cnt <= rx_cnt - 5'd1;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_output_control <= `SOC_RESET;
      end else if (fall_ev && rx_cnt == 5'd1 &&
                   rx_word[17:10] == `SOC_OFFSET) begin
         serial_output_control <= rx_word[9:0];
      end
   end

   // ------------------------------------------------------------
   // filter samples and signatures
   // ------------------------------------------------------------
   logic [23:0] hold_i;
   logic [23:0] hold_q;
   logic pending;
   logic start_frame;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_i <= 24'h000000;
         hold_q <= 24'h000000;
         pending <= 1'b0;
      end else if (sample_valid) begin
         hold_i <= sample_i;
         hold_q <= sample_q;
         pending <= 1'b1;
      end else if (start_frame) begin
         pending <= 1'b0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sig_i <= 16'h0000;
         sig_q <= 16'h0000;
      end else if (sample_valid &&
                   serial_output_control[`SOC_ROUTE_BIT]) begin
         sig_i <= sample_i[23:8];
         sig_q <= sample_q[23:8];
      end
   end

   // ------------------------------------------------------------
   // frame transmitter
   // ------------------------------------------------------------
   rsp_pkg::tx_state_t state;
   logic [5:0] idx;
   logic [5:0] wl;
   logic [5:0] last_idx;
   logic [1:0] fs_mode;
   logic is_last;
   logic sync_seen;
   logic [23:0] tx_i;
   logic [23:0] tx_q;
   logic sdo_o;
   logic sdo_oe;
   logic fs_o;
   logic fe;
   assign wl = rsp_pkg::word_len(
      serial_output_control[`SOC_WL_HI:`SOC_WL_LO]);
   assign last_idx = {wl[4:0], 1'b0} - 6'd1;
   assign fs_mode = serial_output_control[`SOC_FS_HI:`SOC_FS_LO];
   assign is_last = state == rsp_pkg::ST_SHIFT && idx == last_idx;

   function automatic logic bit_of(input logic [23:0] wi,
      input logic [23:0] wq, input logic [5:0] n, input logic [5:0] len);
      logic [5:0] pos;
      pos = (n < len) ? n : n - len;
      return (n < len) ? wi[5'd23 - pos[4:0]] : wq[5'd23 - pos[4:0]];
   endfunction

   // a sync counts only when idle or during the last bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_seen <= 1'b0;
      end else if (fall_ev && !port_master_select && sync2[1] &&
                   (state == rsp_pkg::ST_IDLE || is_last)) begin
         sync_seen <= 1'b1;
      end else if (rise_ev) begin
         sync_seen <= 1'b0;
      end
   end

   assign start_frame = rise_ev && (
      (state == rsp_pkg::ST_SYNC) ||
      (state == rsp_pkg::ST_IDLE && port_master_select && pending &&
       fs_mode == 2'b01) ||
      (!port_master_select && sync_seen &&
       (state == rsp_pkg::ST_IDLE || is_last)));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= rsp_pkg::ST_IDLE;
         idx <= 6'd0;
         tx_i <= 24'h000000;
         tx_q <= 24'h000000;
         sdo_o <= 1'b0;
         sdo_oe <= 1'b0;
         fs_o <= 1'b0;
         fe <= 1'b0;
      end else if (start_frame) begin
         state <= rsp_pkg::ST_SHIFT;
         idx <= 6'd0;
         tx_i <= hold_i;
         tx_q <= hold_q;
         sdo_oe <= 1'b1;
         sdo_o <= bit_of(hold_i, hold_q, 6'd0, wl);
         fs_o <= port_master_select && fs_mode == 2'b01;
         fe <= 1'b0;
      end else if (rise_ev) begin
         unique case (state)
            rsp_pkg::ST_IDLE: begin
               if (port_master_select && pending) begin
                  state <= rsp_pkg::ST_SYNC;
                  fs_o <= 1'b1;
               end
            end
            rsp_pkg::ST_SYNC: begin
               fs_o <= 1'b0;
            end
            rsp_pkg::ST_SHIFT: begin
               if (idx == last_idx) begin
                  state <= rsp_pkg::ST_IDLE;
                  sdo_oe <= 1'b0;
                  sdo_o <= 1'b0;
                  fs_o <= 1'b0;
                  fe <= 1'b0;
               end else begin
                  idx <= idx + 6'd1;
                  sdo_o <= bit_of(tx_i, tx_q, idx + 6'd1, wl);
                  fe <= (idx + 6'd1) == last_idx;
                  fs_o <= port_master_select && (fs_mode == 2'b01 ||
                     (fs_mode[1] && (idx + 6'd1) == wl - 6'd1));
               end
            end
         endcase
      end
   end

   assign link.sdo_o = sdo_o;
   assign link.sdo_oe = sdo_oe;
   assign link.frame_end = fe;
   assign link.dev_fs_o = fs_o;
   assign link.dev_fs_oe = port_master_select;
endmodule // serial_port_device
`default_nettype wire

/* design/serial_port_host.sv */
// partner end of the serial output link with an ahb-lite register port
`include "rsp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module serial_port_host (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   serial_link_if.host link
);
   // ------------------------------------------------------------
   // link synchronisers and bit clock
   // ------------------------------------------------------------
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic sclk_prev;
   logic [6:0] ctrl;
   logic [4:0] div_cnt;
   logic gen_clk;
   logic tick;
   logic rise_ev;
   logic fall_ev;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         sclk_prev <= 1'b0;
      end else begin
         sync1 <= {link.sclk, link.serial_data_output_line, link.frame_end};
         sync2 <= sync1;
         sclk_prev <= sync2[2];
      end
   end
   assign tick = ctrl[0] && div_cnt == 5'd0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= 5'd0;
         gen_clk <= 1'b0;
      end else if (!ctrl[0]) begin
         div_cnt <= 5'd0;
         gen_clk <= 1'b0;
      end else if (tick) begin
         div_cnt <= 5'(`SCLK_MIN_HALF) - 5'd1 + {1'b0, ctrl[4:1]};
         gen_clk <= ~gen_clk;
      end else begin
         div_cnt <= div_cnt - 5'd1;
      end
   end
   assign rise_ev = ctrl[0] ? (tick && !gen_clk) : (sync2[2] && !sclk_prev);
   assign fall_ev = ctrl[0] ? (tick && gen_clk) : (!sync2[2] && sclk_prev);
   assign link.host_sclk_o = gen_clk;
   assign link.host_sclk_oe = ctrl[0];

   // ------------------------------------------------------------
   // bus slave: registered read data, no wait states
   // ------------------------------------------------------------
   logic dp_write;
   logic [7:0] dp_addr;
   logic [23:0] rx_i;
   logic [23:0] rx_q;
   logic rx_done;
   logic sync_req;
   logic fs_o;
   logic ctl_o;
   logic [4:0] tx_cnt;
   logic [18:0] tx_sh;
   logic wr_ctrl;
   logic wr_sync;
   logic wr_cmd;
   logic wr_status;
   assign wr_ctrl = dp_write && dp_addr == `HOST_CTRL;
   assign wr_sync = dp_write && dp_addr == `HOST_SYNC;
   assign wr_cmd = dp_write && dp_addr == `HOST_CMD;
   assign wr_status = dp_write && dp_addr == `HOST_STATUS;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (hready) begin
         dp_write <= hsel && htrans[1] && hwrite;
         dp_addr <= haddr[7:0];
         unique case (haddr[7:0])
            `HOST_CTRL: hrdata <= {25'h0000000, ctrl};
            `HOST_STATUS: hrdata <= {29'h00000000, sync_req,
                                     tx_cnt != 5'd0, rx_done};
            `HOST_RX_I: hrdata <= {8'h00, rx_i};
            `HOST_RX_Q: hrdata <= {8'h00, rx_q};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `HOST_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= hwdata[6:0];
      end
   end

   // ------------------------------------------------------------
   // receiver: frame end marks the last bit of a slot
   // ------------------------------------------------------------
   logic [47:0] rx_sh;
   logic [47:0] rx_word;
   logic [5:0] wl;
   logic [23:0] mask;
   assign rx_word = {rx_sh[46:0], sync2[1]};
   assign wl = rsp_pkg::word_len(ctrl[6:5]);
   assign mask = 24'hffffff >> (6'd24 - wl);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_sh <= 48'h000000000000;
         rx_i <= 24'h000000;
         rx_q <= 24'h000000;
      end else if (fall_ev) begin
         rx_sh <= rx_word;
         if (sync2[0]) begin
            rx_q <= rx_word[23:0] & mask;
            rx_i <= 24'(rx_word >> wl) & mask;
         end
      end
   end
   // a new frame wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_done <= 1'b0;
      end else if (fall_ev && sync2[0]) begin
         rx_done <= 1'b1;
      end else if (wr_status && hwdata[0]) begin
         rx_done <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // frame sync pulse when this end makes the clock
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_req <= 1'b0;
         fs_o <= 1'b0;
      end else if (rise_ev) begin
         fs_o <= sync_req && ctrl[0];
         sync_req <= wr_sync;
      end else if (wr_sync) begin
         sync_req <= 1'b1;
      end
   end
   assign link.host_fs_o = fs_o;
   assign link.host_fs_oe = ctrl[0];

   // ------------------------------------------------------------
   // control writer: start bit, address, data, msb first
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_cnt <= 5'd0;
         tx_sh <= 19'h00000;
         ctl_o <= 1'b0;
      end else if (wr_cmd && tx_cnt == 5'd0) begin
         tx_sh <= {1'b1, hwdata[17:0]};
         tx_cnt <= `CTL_FRAME_BITS;
      end else if (rise_ev) begin
         if (tx_cnt != 5'd0) begin
            ctl_o <= tx_sh[18];
            tx_sh <= {tx_sh[17:0], 1'b0};
            tx_cnt <= tx_cnt - 5'd1;
         end else begin
            ctl_o <= 1'b0;
         end
      end
   end
   assign link.serial_control_input = ctl_o;
endmodule // serial_port_host
`default_nettype wire

/* verif/rsp_link_checker.sv */
// assertions on the serial output link between the two ends
`timescale 1ns/10ps
`default_nettype none
module rsp_link_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sclk,
   input wire logic frame_sync,
   input wire logic host_fs_oe,
   input wire logic sdo_oe,
   input wire logic serial_data_output_line,
   input wire logic frame_end
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic sclk_d;
   logic [5:0] run;
   logic [5:0] rise_age;
   logic [5:0] fs_age;
   // a slave sees wire edges a few cycles late, hence the slack below
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_d <= 1'b0;
         run <= 6'h3f;
         rise_age <= 6'h3f;
      end else begin
         sclk_d <= sclk;
         run <= (sclk != sclk_d) ? 6'h00 : run + {5'h00, run != 6'h3f};
         if (sclk & ~sclk_d) rise_age <= 6'h00;
         else if (rise_age != 6'h3f) rise_age <= rise_age + 6'h01;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) fs_age <= 6'h3f;
      else if (frame_sync) fs_age <= 6'h00;
      else if (fs_age != 6'h3f) fs_age <= fs_age + 6'h01;
   end
   // ----------------------------------------------------------
   // link properties
   // ----------------------------------------------------------
   property p_clk_min;
      $rose(sclk) |-> run >= 6'h01;
   endproperty
   a_clk_min: assert property (p_clk_min)
      else $error("bit clock low level too short");
   property p_data_hold;
      !sclk && sclk_d |-> $stable(serial_data_output_line);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("data changed at falling edge");
   property p_data_on_rise;
      $changed(serial_data_output_line) |-> sclk && !sclk_d
         || rise_age <= 6'h06;
   endproperty
   a_data_on_rise: assert property (p_data_on_rise)
      else $error("data changed away from rising edge");
   property p_end_in_slot;
      frame_end |-> sdo_oe;
   endproperty
   a_end_in_slot: assert property (p_end_in_slot)
      else $error("frame end outside the slot");
   property p_end_len;
      $rose(frame_end) |-> frame_end [*8] ##[1:12] !frame_end;
   endproperty
   a_end_len: assert property (p_end_len)
      else $error("frame end not one bit long");
   property p_oe_after_sync;
      $rose(sdo_oe) |-> frame_sync || fs_age <= 6'h18;
   endproperty
   a_oe_after_sync: assert property (p_oe_after_sync)
      else $error("driver enabled without a sync");
   property p_oe_off_end;
      $fell(sdo_oe) |-> $fell(frame_end);
   endproperty
   a_oe_off_end: assert property (p_oe_off_end)
      else $error("driver released away from frame end");
   property p_start;
      $fell(frame_sync) && host_fs_oe && !sdo_oe |-> ##[1:8] sdo_oe;
   endproperty
   a_start: assert property (p_start)
      else $error("frame did not start after sync");
endmodule // rsp_link_checker
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for both ends of the serial output link
`include "rsp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic boot_master_select_pin = 1'b0;
   logic sample_valid = 1'b0;
   logic [23:0] sample_i = 24'h0;
   logic [23:0] sample_q = 24'h0;
   logic [15:0] sig_i;
   logic [15:0] sig_q;
   logic [9:0] serial_output_control;
   logic port_master_select;
   logic sclk_q = 1'b0;
   logic [31:0] rd;
   int fails = 0;
   int checked = 0;
   int bits = 0;
   int syncs = 0;
   always #2 hclk = ~hclk;
   serial_link_if link ();
   serial_port_device #(.PORT_INDEX(0)) serial_port_device_i (
      .hclk(hclk), .hresetn(hresetn), .link(link.device),
      .boot_master_select_pin(boot_master_select_pin),
      .sample_valid(sample_valid), .sample_i(sample_i),
      .sample_q(sample_q), .sig_i(sig_i), .sig_q(sig_q),
      .serial_output_control(serial_output_control),
      .port_master_select(port_master_select));
   serial_port_host serial_port_host_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .link(link.host));
   rsp_link_checker rsp_link_checker_i (
      .hclk(hclk), .hresetn(hresetn), .sclk(link.sclk),
      .frame_sync(link.frame_sync), .host_fs_oe(link.host_fs_oe),
      .sdo_oe(link.sdo_oe), .frame_end(link.frame_end),
      .serial_data_output_line(link.serial_data_output_line));
   // count bits shifted while the driver is on; negedge avoids races
   always @(negedge hclk) begin
      sclk_q <= link.sclk;
      if (link.sclk && !sclk_q && link.sdo_oe) bits++;
      if (link.sclk && !sclk_q && link.frame_sync) syncs++;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // ----------------------------------------------------------
   // ahb-lite single word transfers
   // ----------------------------------------------------------
   task automatic ahb(input logic wr, input logic [7:0] a,
         input logic [31:0] wd);
      logic r;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin
         @(negedge hclk);
         r = hreadyout;
         @(posedge hclk);
      end while (r !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(negedge hclk);
         r = hreadyout;
         rd = hrdata;
         @(posedge hclk);
      end while (r !== 1'b1);
   endtask
   task automatic status_wait(input int b, input logic v);
      do ahb(1'b0, `HOST_STATUS, 32'h0); while (rd[b] !== v);
   endtask
   // settle covers the device's late view of the last control bit
   task automatic cmd(input logic [7:0] a, input logic [9:0] d);
      ahb(1'b1, `HOST_CMD, {14'h0, a, d});
      status_wait(1, 1'b0);
      repeat (48) @(posedge hclk);
   endtask
   task automatic pulse(input logic [23:0] si, input logic [23:0] sq);
      @(posedge hclk);
      sample_i <= si;
      sample_q <= sq;
      sample_valid <= 1'b1;
      @(posedge hclk);
      sample_valid <= 1'b0;
      @(negedge hclk);
   endtask
   task automatic frame(input logic [1:0] c, input logic [1:0] f,
         input logic [23:0] si, input logic [23:0] sq);
      int wl;
      int ns;
      wl = c[1] ? 24 : (c[0] ? 16 : 12);
      ns = f[1] ? 2 : (f[0] ? 2 * wl : 1);
      pulse(si, sq);
      bits = 0;
      syncs = 0;
      if (!port_master_select) begin
         ahb(1'b1, `HOST_SYNC, 32'h0);
         repeat (64) @(posedge hclk);
         // a second sync inside the slot must not restart it
         ahb(1'b1, `HOST_SYNC, 32'h0);
         ns = 2;
      end
      status_wait(0, 1'b1);
      repeat (48) @(posedge hclk);
      chk(bits, 2 * wl);
      chk(syncs, ns);
      ahb(1'b0, `HOST_RX_I, 32'h0);
      chk(rd, {8'h0, si} >> (24 - wl));
      ahb(1'b0, `HOST_RX_Q, 32'h0);
      chk(rd, {8'h0, sq} >> (24 - wl));
      ahb(1'b1, `HOST_STATUS, 32'h1);
      ahb(1'b0, `HOST_STATUS, 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
   endtask
   initial begin
      #200000;
      fails++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, `HOST_CTRL, 32'h0);
      chk(rd, {25'h0, `HOST_CTRL_RESET});
      chk({31'h0, hresp}, 32'h0);
      ahb(1'b1, 8'h18, 32'hffff_ffff);
      ahb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h0);
      chk({22'h0, serial_output_control}, {22'h0, `SOC_RESET});
      chk({31'h0, port_master_select}, 32'h0);
      for (int c = 0; c < 4; c++) begin
         ahb(1'b1, `HOST_CTRL, {25'h0, c[1:0], 4'h6, 1'b1});
         cmd(`SOC_OFFSET, {3'h0, c[1:0], 5'h0});
         chk({22'h0, serial_output_control}, {25'h0, c[1:0], 5'h0});
         frame(c[1:0], 2'h0, 24'hc35a96 ^ {22'h0, c[1:0]}, 24'h3ca569);
      end
      cmd(8'ha8, 10'h3ff);
      chk({22'h0, serial_output_control}, 32'h60);
      chk({16'h0, sig_i}, 32'h0);
      cmd(`SOC_OFFSET, 10'h200);
      pulse(24'habcdef, 24'h123456);
      chk({16'h0, sig_i}, 32'habcd);
      chk({16'h0, sig_q}, 32'h1234);
      // slow the device's own divider before it takes the clock over
      cmd(`SOC_OFFSET, 10'h006);
      ahb(1'b1, `HOST_CTRL, 32'h0);
      boot_master_select_pin <= 1'b1;
      for (int n = 0; n < 64 && port_master_select !== 1'b1; n++)
         @(posedge hclk);
      chk({31'h0, port_master_select}, 32'h1);
      repeat (1000) @(posedge hclk);
      ahb(1'b1, `HOST_STATUS, 32'h1);
      frame(2'h0, 2'h0, 24'h5a5a5a, 24'ha5a5a5);
      cmd(`SOC_OFFSET, 10'h086);
      frame(2'h0, 2'h1, 24'h0f1e2d, 24'h3c4b5a);
      cmd(`SOC_OFFSET, 10'h106);
      frame(2'h0, 2'h2, 24'h69788a, 24'h9aabbc);
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
